// file: logic/rsq_reset_isp.sv
// Reset sequencing, register file and serial test pin control.
// Assumes reset_n is the internal power-on reset and the reset pin is asynchronous.
//
// Notes on behaviour
// - Device stays in reset 120 ns after release; no access before then. Writes are ignored in reset; reads still return register values.
// - Power-up leaves the flash state machine in read array mode.
// - Logic outputs valid in warm reset; after config load at power-on.
// - In power down, macrocell outputs hold; array inputs pass with address blocked.
// - Power-on clears macrocell flops; otherwise only reset/preset terms act.
// - Any reset clears code-space and peripheral bits; rest from config.
// - Reset pin aborts program or erase; read mode after 25 us.
// - Register two bits 0,2-6 disconnect address and controls from array.
// - Test pin enable is OR of config bit, register bit, product term.
// - Enabled pins all inputs; data out drives only after enable command.
// - The enable command may also enable status and error pins.
// - With enable false the four pins are ordinary general I/O.
// - A blank part enables the four test pins by default.
// - Port E bits 0..5 carry mode, clock, in, out, status, error.
// - Config bit set dedicates the test pins whatever else.
// - Run-time enable is bit 0 at offset C7h; other bits read zero.
// - Run-time enable cleared by any reset and by a write of zero.
// - A dedicated product term can enable the test pins.
// - Reset aborts programming when pins enabled by register, not by config.
// - Power management registers cleared only at power-up.
`timescale 1ns/1ps
module rsq_reset_isp #(
    parameter int POR_CYCLES_P = rsq_pkg::POR_CYCLES
) (
    // Clock and power-on reset
    input  wire logic                 core_clk,
    input  wire logic                 reset_n,
    // External reset pin
    input  wire logic                 reset_pin_n,
    // Stored configuration
    input  wire rsq_pkg::rsq_cfg_t    cfg,
    // Register port on the I/O base
    input  wire logic                 io_sel,
    input  wire logic [7:0]           io_addr,
    input  wire logic                 io_wr,
    input  wire logic                 io_rd,
    input  wire logic [7:0]           io_wdata,
    output logic [7:0]                io_rdata,
    // Device status
    output logic                      dev_ready,
    output logic                      plo_valid,
    output logic [7:0]                memory_map_control_reg,
    // Flash state machine requests
    input  wire logic                 flash_prog_start,
    input  wire logic                 flash_erase_start,
    input  wire logic                 flash_op_done,
    output logic                      flash_read_mode,
    output logic                      flash_busy,
    // Logic array inputs and macrocells
    input  wire rsq_pkg::rsq_pld_in_t pld_raw,
    output rsq_pkg::rsq_pld_in_t      pld_gated,
    input  wire logic                 power_down,
    input  wire logic [7:0]           mc_d,
    input  wire logic [7:0]           mc_re,
    input  wire logic [7:0]           mc_pr,
    output logic [7:0]                mc_q,
    // Serial programming engine side
    input  wire logic                 test_pin_select_term,
    input  wire logic                 isp_enable_cmd,
    input  wire logic                 isp_ext_opt,
    input  wire logic                 isp_disable_cmd,
    input  wire logic                 isp_tdo,
    input  wire logic                 isp_error_n,
    output logic                      isp_pins_on,
    output logic                      isp_active,
    output logic                      isp_abort,
    output logic                      isp_tms,
    output logic                      isp_tck,
    output logic                      isp_tdi,
    output logic                      isp_status_pin,
    output logic                      isp_error_pin,
    // Port E general I/O side
    input  wire logic [7:0]           gpio_out,
    input  wire logic [7:0]           gpio_oe,
    output logic [7:0]                gpio_in,
    // Port E pins
    input  wire logic [7:0]           pe_in,
    output logic [7:0]                pe_out,
    output logic [7:0]                pe_oe
);
    import rsq_pkg::*;

    // Reset pin synchroniser
    logic rst_s1_reg;
    logic rst_s2_reg;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= reset_pin_n;
            rst_s2_reg <= rst_s1_reg;
        end
    end

    logic pin_rst;
    assign pin_rst = ~rst_s2_reg;

    // Configuration load after power-on
    logic     cfg_loaded_reg;
    rsq_cfg_t cfg_reg;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_loaded_reg <= 1'b0;
            cfg_reg        <= '0;
        end else if (!cfg_loaded_reg) begin
            cfg_loaded_reg <= 1'b1;
            cfg_reg        <= cfg;
        end
    end

    assign plo_valid = cfg_loaded_reg;

    // Power-on hold: the device finishes loading while the pin is held
    logic [POR_CNT_W-1:0] por_cnt_reg;
    logic                 por_done_reg;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            por_cnt_reg  <= '0;
            por_done_reg <= 1'b0;
        end else if (!por_done_reg) begin
            if (por_cnt_reg >= POR_CNT_W'(POR_CYCLES_P - 1)) begin
                por_done_reg <= 1'b1;
            end
            por_cnt_reg <= por_cnt_reg + POR_CNT_W'(1);
        end
    end

    // Internal reset and recovery
    logic                 dev_rst;
    logic [REC_CNT_W-1:0] rec_cnt_reg;

    assign dev_rst = pin_rst | ~por_done_reg | ~cfg_loaded_reg;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rec_cnt_reg <= REC_CNT_W'(REC_CYCLES);
        end else if (dev_rst) begin
            rec_cnt_reg <= REC_CNT_W'(REC_CYCLES);
        end else if (rec_cnt_reg != '0) begin
            rec_cnt_reg <= rec_cnt_reg - REC_CNT_W'(1);
        end
    end

    logic in_reset;
    assign in_reset  = dev_rst | (rec_cnt_reg != '0);
    assign dev_ready = ~in_reset;

    // Register writes
    logic io_hit_wr;
    assign io_hit_wr = io_sel & io_wr & ~in_reset;

    logic [7:0] debug_pin_enable_reg;
    logic [7:0] power_mgmt_mode_reg_zero;
    logic [7:0] power_mgmt_mode_reg_two;
    logic [7:0] memmap_reg;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            debug_pin_enable_reg <= REG_RESET_VAL;
        end else if (in_reset) begin
            debug_pin_enable_reg <= REG_RESET_VAL;
        end else if (io_hit_wr && io_addr == OFS_DEBUG_PIN_EN) begin
            debug_pin_enable_reg <= io_wdata & DEBUG_PIN_EN_MASK;
        end
    end

    // Untouched by the reset pin
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            power_mgmt_mode_reg_zero <= REG_RESET_VAL;
            power_mgmt_mode_reg_two  <= REG_RESET_VAL;
        end else if (io_hit_wr) begin
            if (io_addr == OFS_PMMR_ZERO) begin
                power_mgmt_mode_reg_zero <= io_wdata & PMMR_ZERO_MASK;
            end
            if (io_addr == OFS_PMMR_TWO) begin
                power_mgmt_mode_reg_two <= io_wdata & PMMR_TWO_MASK;
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            memmap_reg <= REG_RESET_VAL;
        end else if (in_reset) begin
            memmap_reg <= cfg_reg.memmap_default & ~MEMMAP_CLEAR_MASK;
        end else if (io_hit_wr && io_addr == OFS_MEMMAP) begin
            memmap_reg <= io_wdata;
        end
    end

    assign memory_map_control_reg = memmap_reg;

    // Register reads
    logic [7:0] rdata_reg;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_reg <= REG_RESET_VAL;
        end else if (io_sel && io_rd) begin
            case (io_addr)
                OFS_DEBUG_PIN_EN: rdata_reg <= debug_pin_enable_reg;
                OFS_PMMR_ZERO:    rdata_reg <= power_mgmt_mode_reg_zero;
                OFS_PMMR_TWO:     rdata_reg <= power_mgmt_mode_reg_two;
                OFS_MEMMAP:       rdata_reg <= memmap_reg;
                default:          rdata_reg <= REG_RESET_VAL;
            endcase
        end
    end

    assign io_rdata = rdata_reg;

    // Flash state machine
    rsq_flash_state_t       fl_state_reg;
    logic [ABORT_CNT_W-1:0] abort_cnt_reg;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            fl_state_reg  <= FL_READ_ARRAY;
            abort_cnt_reg <= '0;
        end else begin
            case (fl_state_reg)
                FL_READ_ARRAY: begin
                    if (!in_reset && flash_prog_start) begin
                        fl_state_reg <= FL_PROGRAM;
                    end else if (!in_reset && flash_erase_start) begin
                        fl_state_reg <= FL_ERASE;
                    end
                end
                FL_PROGRAM, FL_ERASE: begin
                    if (pin_rst) begin
                        fl_state_reg  <= FL_ABORT;
                        abort_cnt_reg <= ABORT_CNT_W'(ABORT_CYCLES - 1);
                    end else if (flash_op_done) begin
                        fl_state_reg <= FL_READ_ARRAY;
                    end
                end
                FL_ABORT: begin
                    if (abort_cnt_reg == '0) begin
                        fl_state_reg <= FL_READ_ARRAY;
                    end else begin
                        abort_cnt_reg <= abort_cnt_reg - ABORT_CNT_W'(1);
                    end
                end
                default: begin
                    fl_state_reg <= FL_READ_ARRAY;
                end
            endcase
        end
    end

    assign flash_read_mode = (fl_state_reg == FL_READ_ARRAY);
    assign flash_busy      = ~flash_read_mode;

    // Logic array input blocking
    rsq_pld_gate u_pld_gate (
        .core_clk                (core_clk),
        .reset_n                 (reset_n),
        .pld_raw                 (pld_raw),
        .power_mgmt_mode_reg_two (power_mgmt_mode_reg_two),
        .power_down              (power_down),
        .pld_gated               (pld_gated)
    );

    // Output macrocells
    logic [MC_COUNT-1:0] mc_reg;
    logic                mc_hold;
    assign mc_hold = in_reset | power_down;

    genvar m;
    generate
        for (m = 0; m < MC_COUNT; m = m + 1) begin : g_mc
            always_ff @(posedge core_clk or negedge reset_n) begin
                if (!reset_n) begin
                    mc_reg[m] <= 1'b0;
                end else if (mc_re[m]) begin
                    mc_reg[m] <= 1'b0;
                end else if (mc_pr[m]) begin
                    mc_reg[m] <= 1'b1;
                end else if (!mc_hold) begin
                    mc_reg[m] <= mc_d[m];
                end
            end
        end
    endgenerate

    assign mc_q = mc_reg;

    // Test pin enable
    logic cfg_dedicates;
    logic pins_on;
    assign cfg_dedicates = cfg_reg.isp_dedicated | cfg_reg.blank;
    assign pins_on = cfg_loaded_reg &
                     (cfg_dedicates |
                      debug_pin_enable_reg[DEBUG_PIN_EN_BIT] |
                      test_pin_select_term);
    assign isp_pins_on = pins_on;

    // Channel state: output driver and extension pins
    logic chan_on_reg;
    logic ext_on_reg;
    logic isp_kill;
    assign isp_kill = ~pins_on | (in_reset & ~cfg_dedicates);

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            chan_on_reg <= 1'b0;
            ext_on_reg  <= 1'b0;
        end else if (isp_kill || isp_disable_cmd) begin
            chan_on_reg <= 1'b0;
            ext_on_reg  <= 1'b0;
        end else if (isp_enable_cmd) begin
            chan_on_reg <= 1'b1;
            ext_on_reg  <= isp_ext_opt;
        end
    end

    assign isp_active = chan_on_reg;
    assign isp_abort  = pins_on & in_reset & ~cfg_dedicates;

    // Port E input synchroniser
    logic [PE_WIDTH-1:0] pe_s1_reg;
    logic [PE_WIDTH-1:0] pe_s2_reg;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pe_s1_reg <= '0;
            pe_s2_reg <= '0;
        end else begin
            pe_s1_reg <= pe_in;
            pe_s2_reg <= pe_s1_reg;
        end
    end

    assign isp_tms = pins_on & pe_s2_reg[PE_TMS];
    assign isp_tck = pins_on & pe_s2_reg[PE_TCK];
    assign isp_tdi = pins_on & pe_s2_reg[PE_TDI];
    assign gpio_in = pe_s2_reg;

    // Port E output registers
    logic [PE_WIDTH-1:0] pe_out_reg;
    logic [PE_WIDTH-1:0] pe_oe_reg;
    logic [PE_WIDTH-1:0] isp_mask;
    logic [PE_WIDTH-1:0] isp_oe;
    logic [PE_WIDTH-1:0] isp_val;

    always_comb begin
        isp_mask          = '0;
        isp_oe            = '0;
        isp_val           = '0;
        isp_mask[PE_TMS]  = pins_on;
        isp_mask[PE_TCK]  = pins_on;
        isp_mask[PE_TDI]  = pins_on;
        isp_mask[PE_TDO]  = pins_on;
        isp_mask[PE_STAT] = ext_on_reg;
        isp_mask[PE_ERR]  = ext_on_reg;
        isp_oe[PE_TDO]    = chan_on_reg;
        isp_oe[PE_STAT]   = ext_on_reg;
        isp_oe[PE_ERR]    = ext_on_reg;
        isp_val[PE_TDO]   = isp_tdo;
        isp_val[PE_STAT]  = flash_read_mode;
        isp_val[PE_ERR]   = isp_error_n;
    end

    // General I/O held as inputs through reset
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pe_out_reg <= '0;
            pe_oe_reg  <= '0;
        end else begin
            pe_out_reg <= (isp_mask & isp_val) | (~isp_mask & gpio_out);
            pe_oe_reg  <= (isp_mask & isp_oe) |
                          (~isp_mask & gpio_oe & {PE_WIDTH{~in_reset}});
        end
    end

    assign pe_out         = pe_out_reg;
    assign pe_oe          = pe_oe_reg;
    assign isp_status_pin = pe_out_reg[PE_STAT];
    assign isp_error_pin  = pe_out_reg[PE_ERR];

endmodule : rsq_reset_isp

// file: logic/rsq_pkg.sv
// Shared constants and types for the reset sequencer and serial test pin enable.
// Assumes a single 20 MHz core clock and an 8-bit register port on the I/O base.
package rsq_pkg;

    // Clock and timing figures
    localparam int CLK_PERIOD_NS    = 50;
    localparam int POR_WIDTH_NS     = 1000000;
    localparam int RECOVERY_NS      = 120;
    localparam int FLASH_ABORT_NS   = 25000;
    localparam int POR_CYCLES       = (POR_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REC_RAW          = RECOVERY_NS / CLK_PERIOD_NS;
    localparam int REC_CYCLES       = (REC_RAW < 1) ? 1 : REC_RAW;
    localparam int ABORT_CYCLES     = (FLASH_ABORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Counter widths
    localparam int POR_CNT_W        = 24;
    localparam int ABORT_CNT_W      = 10;
    localparam int REC_CNT_W        = 3;

    // Register offsets from the I/O register base
    localparam logic [7:0] OFS_DEBUG_PIN_EN = 8'hC7;
    localparam logic [7:0] OFS_PMMR_ZERO    = 8'hB0;
    localparam logic [7:0] OFS_PMMR_TWO     = 8'hB4;
    localparam logic [7:0] OFS_MEMMAP       = 8'hE0;

    // Writable bits and reset values
    localparam logic [7:0] DEBUG_PIN_EN_MASK = 8'h01;
    localparam logic [7:0] PMMR_ZERO_MASK    = 8'h3A;
    localparam logic [7:0] PMMR_TWO_MASK     = 8'h7D;
    localparam logic [7:0] MEMMAP_CLEAR_MASK = 8'h81;
    localparam logic [7:0] REG_RESET_VAL     = 8'h00;
    localparam int         DEBUG_PIN_EN_BIT  = 0;

    // Power management register two field positions
    localparam int P2_ADDR_BIT      = 0;
    localparam int P2_CTL0_BIT      = 2;
    localparam int P2_CTL1_BIT      = 3;
    localparam int P2_CTL2_BIT      = 4;
    localparam int P2_ALE_BIT       = 5;
    localparam int P2_DBE_BIT       = 6;

    // Port E pin positions
    localparam int PE_WIDTH         = 8;
    localparam int PE_TMS           = 0;
    localparam int PE_TCK           = 1;
    localparam int PE_TDI           = 2;
    localparam int PE_TDO           = 3;
    localparam int PE_STAT          = 4;
    localparam int PE_ERR           = 5;

    localparam int MC_COUNT         = 8;

    typedef enum {
        FL_READ_ARRAY,
        FL_PROGRAM,
        FL_ERASE,
        FL_ABORT
    } rsq_flash_state_t;

    // Microcontroller inputs to the logic array
    typedef struct packed {
        logic [7:0] addr;
        logic [2:0] ctl;
        logic       ale;
        logic       dbe;
    } rsq_pld_in_t;

    // Stored configuration presented by the nonvolatile cells
    typedef struct packed {
        logic       isp_dedicated;
        logic       blank;
        logic [7:0] memmap_default;
    } rsq_cfg_t;

endpackage : rsq_pkg

// file: logic/rsq_pld_gate.sv
// Synchronises microcontroller inputs and blocks them from the logic array.
// Assumes raw inputs arrive from pins, and the mask register on the core clock.
`timescale 1ns/1ps
module rsq_pld_gate (
    // Clock and reset
    input  wire logic                core_clk,
    input  wire logic                reset_n,
    // Raw pin inputs
    input  wire rsq_pkg::rsq_pld_in_t pld_raw,
    // Blocking controls
    input  wire logic [7:0]          power_mgmt_mode_reg_two,
    input  wire logic                power_down,
    // Gated inputs to the array
    output rsq_pkg::rsq_pld_in_t      pld_gated
);
    import rsq_pkg::*;

    localparam int W = $bits(rsq_pld_in_t);

    logic [W-1:0] block;
    logic [W-1:0] sync1_reg;
    logic [W-1:0] sync2_reg;
    logic [W-1:0] gated_reg;

    // Address also blocked during power down
    assign block = {{8{power_mgmt_mode_reg_two[P2_ADDR_BIT] | power_down}},
                    power_mgmt_mode_reg_two[P2_CTL2_BIT],
                    power_mgmt_mode_reg_two[P2_CTL1_BIT],
                    power_mgmt_mode_reg_two[P2_CTL0_BIT],
                    power_mgmt_mode_reg_two[P2_ALE_BIT],
                    power_mgmt_mode_reg_two[P2_DBE_BIT]};

    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            always_ff @(posedge core_clk or negedge reset_n) begin
                if (!reset_n) begin
                    sync1_reg[i] <= 1'b0;
                    sync2_reg[i] <= 1'b0;
                    gated_reg[i] <= 1'b0;
                end else begin
                    sync1_reg[i] <= pld_raw[i];
                    sync2_reg[i] <= sync1_reg[i];
                    gated_reg[i] <= sync2_reg[i] & ~block[i];
                end
            end
        end
    endgenerate

    assign pld_gated = gated_reg;

endmodule : rsq_pld_gate

// file: tb/rsq_reset_isp_chk.sv
// Assertions on the reset sequencer and test pin enable ports.
// Assumes one clock domain; bound to the top module below.
`timescale 1ns/1ps
module rsq_reset_isp_chk import rsq_pkg::*; (
    // Clock and reset
    input wire logic       core_clk,
    input wire logic       reset_n,
    input wire logic       reset_pin_n,
    // Register port
    input wire logic       io_sel,
    input wire logic [7:0] io_addr,
    input wire logic       io_rd,
    input wire logic [7:0] io_rdata,
    // Status and pins
    input wire logic       dev_ready,
    input wire logic [7:0] memory_map_control_reg,
    input wire logic       flash_read_mode,
    input wire logic       test_pin_select_term,
    input wire logic       isp_pins_on,
    input wire logic       isp_active,
    input wire logic [7:0] pe_oe
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    property p_term_on; test_pin_select_term |-> isp_pins_on; endproperty
    a_term_on: assert property (p_term_on)
        else $error("term left pins off");
    property p_test_in; $past(isp_pins_on && !isp_active) |-> pe_oe[3:0] == 4'h0; endproperty
    a_test_in: assert property (p_test_in)
        else $error("test pin driven early");
    property p_tdo_out; $past(isp_active && isp_pins_on) |-> pe_oe[PE_TDO]; endproperty
    a_tdo_out: assert property (p_tdo_out)
        else $error("data out not driven");
    property p_rd_c7;
        io_sel && io_rd && io_addr == OFS_DEBUG_PIN_EN |=> io_rdata[7:1] == 7'h00;
    endproperty
    a_rd_c7: assert property (p_rd_c7)
        else $error("unused bits read set");
    property p_warm; $fell(reset_pin_n) |-> ##[1:3] !dev_ready; endproperty
    a_warm: assert property (p_warm)
        else $error("warm reset missed");
    property p_recov; $rose(reset_pin_n) |-> !dev_ready [*3]; endproperty
    a_recov: assert property (p_recov)
        else $error("recovery too short");
    property p_abort;
        $fell(reset_pin_n) && !flash_read_mode |-> ##[1:600] flash_read_mode;
    endproperty
    a_abort: assert property (p_abort)
        else $error("flash not back in read mode");
    property p_mmap;
        $rose(dev_ready) |-> (memory_map_control_reg & MEMMAP_CLEAR_MASK) == 8'h00;
    endproperty
    a_mmap: assert property (p_mmap)
        else $error("memory map bits not cleared");
endmodule : rsq_reset_isp_chk

bind rsq_reset_isp rsq_reset_isp_chk i_rsq_reset_isp_chk (.core_clk, .reset_n, .reset_pin_n,
    .io_sel, .io_addr, .io_rd, .io_rdata, .dev_ready, .memory_map_control_reg,
    .flash_read_mode, .test_pin_select_term, .isp_pins_on, .isp_active, .pe_oe);

// file: tb/rsq_isp_ctrl_model.sv
// Serial programming controller: sends the enable command after a lag.
// Assumes go is a one-cycle request; data out toggles so stale values show.
`timescale 1ns/1ps
module rsq_isp_ctrl_model (
    input  wire logic       core_clk,
    input  wire logic       go,
    input  wire logic [1:0] lag,
    output logic            isp_enable_cmd = 1'h0,
    output logic            isp_ext_opt    = 1'h0,
    output logic            isp_tdo        = 1'h0,
    output logic            isp_error_n    = 1'h1
);
    int cnt = -1;
    always @(posedge core_clk) begin
        cnt <= go ? int'(lag) : (cnt >= 0 ? cnt - 1 : -1);
        isp_enable_cmd <= #1 (cnt == 0);
        isp_ext_opt <= #1 (cnt == 0);
        isp_tdo <= #1 ~isp_tdo;
    end
endmodule : rsq_isp_ctrl_model

// file: tb/test_reset_and_isp_pin_enable.sv
// Self-checking bench for the reset sequencer and test pin enable.
// Assumes a 50 ns clock; inputs change 1 ns after each rising edge.
`timescale 1ns/1ps
module test_reset_and_isp_pin_enable;
    import rsq_pkg::*;
    logic        core_clk = 0, reset_n = 0, reset_pin_n = 1, io_sel = 0, io_wr = 0, io_rd = 0;
    logic        flash_prog_start = 0, power_down = 0, test_pin_select_term = 0, go = 0;
    logic [1:0]  lag = 0;
    logic [7:0]  mc_re = 0, mc_pr = 0;
    logic [7:0]  io_addr = 0, io_wdata = 0, mc_d = 0, gpio_out = 0, gpio_oe = 0, pe_in = 0, d;
    rsq_cfg_t    cfg = '0;
    rsq_pld_in_t pld_raw = '0, pld_gated;
    logic [7:0]  io_rdata, memory_map_control_reg, mc_q, gpio_in, pe_out, pe_oe;
    logic        dev_ready, plo_valid, flash_read_mode, flash_busy, isp_pins_on, isp_active;
    logic        isp_abort, isp_tms, isp_tck, isp_tdi, isp_status_pin, isp_error_pin;
    logic        isp_enable_cmd, isp_ext_opt, isp_tdo, isp_error_n;
    int          fails = 0, num_checks = 0;

    initial forever #25 core_clk = ~core_clk;

    rsq_reset_isp #(.POR_CYCLES_P(8)) i_rsq_reset_isp (
        .core_clk, .reset_n, .reset_pin_n, .cfg, .io_sel, .io_addr, .io_wr, .io_rd,
        .io_wdata, .io_rdata, .dev_ready, .plo_valid, .memory_map_control_reg,
        .flash_prog_start, .flash_erase_start(1'h0), .flash_op_done(1'h0),
        .flash_read_mode, .flash_busy, .pld_raw, .pld_gated, .power_down, .mc_d,
        .mc_re, .mc_pr, .mc_q, .test_pin_select_term, .isp_enable_cmd,
        .isp_ext_opt, .isp_disable_cmd(1'h0), .isp_tdo, .isp_error_n, .isp_pins_on,
        .isp_active, .isp_abort, .isp_tms, .isp_tck, .isp_tdi, .isp_status_pin,
        .isp_error_pin, .gpio_out, .gpio_oe, .gpio_in, .pe_in, .pe_out, .pe_oe);
    rsq_isp_ctrl_model i_rsq_isp_ctrl_model (.core_clk, .go, .lag, .isp_enable_cmd,
        .isp_ext_opt, .isp_tdo, .isp_error_n);

    task automatic chk(string n, logic [12:0] s, logic [12:0] e);
        num_checks++;
        if (s !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task automatic cyc(int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc
    task automatic wr(logic [7:0] a, logic [7:0] v);
        {io_sel, io_wr, io_addr, io_wdata} = {2'h3, a, v};
        cyc(1);
        {io_sel, io_wr} = 2'h0;
        cyc(1);
    endtask : wr
    task automatic rd(logic [7:0] a, logic [7:0] e);
        {io_sel, io_rd, io_addr} = {2'h3, a};
        cyc(1);
        {io_sel, io_rd} = 2'h0;
        chk("rdata", io_rdata, e);
        cyc(1);
    endtask : rd
    task automatic wait_ready();
        for (int n = 0; n < 100 && dev_ready !== 1'h1; n++) cyc(1);
        chk("ready", dev_ready, 1'h1);
    endtask : wait_ready
    task automatic por(logic [1:0] kind);
        reset_n = 0;
        cfg = {kind, 8'($urandom)};
        cyc(16);
        chk("flrd", flash_read_mode, 1'h1);
        chk("mcq", mc_q, 8'h00);
        reset_n = 1;
        wait_ready();
    endtask : por
    task automatic print_verdict();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict

    initial begin
        #300us;
        fails++;
        print_verdict();
    end

    initial begin
        void'($urandom(80617));
        mc_d = 8'($urandom);
        por(2'h0);
        chk("mmap", memory_map_control_reg, cfg.memmap_default & ~MEMMAP_CLEAR_MASK);
        chk("plo", plo_valid, 1'h1);
        rd(OFS_PMMR_TWO, 8'h00);
        wr(8'h11, 8'hFF);
        rd(8'h11, 8'h00);
        d = 8'($urandom);
        wr(OFS_PMMR_ZERO, d);
        rd(OFS_PMMR_ZERO, d & PMMR_ZERO_MASK);
        wr(OFS_PMMR_TWO, 8'h7D);
        pld_raw = 13'($urandom);
        cyc(4);
        chk("gate", pld_gated, 13'h0000);
        wr(OFS_DEBUG_PIN_EN, 8'hFF);
        rd(OFS_DEBUG_PIN_EN, 8'h01);
        chk("on", isp_pins_on, 1'h1);
        pe_in = 8'($urandom);
        cyc(4);
        chk("tap", {isp_tdi, isp_tck, isp_tms}, pe_in[2:0]);
        chk("gin", {flash_busy, gpio_in}, {1'h0, pe_in});
        chk("in", pe_oe[3:0], 4'h0);
        lag = 2'($urandom);
        go = 1;
        cyc(1);
        go = 0;
        cyc(8);
        chk("act", isp_active, 1'h1);
        chk("oe", pe_oe[5:3], 3'h7);
        chk("stat", pe_out[PE_STAT], 1'h1);
        chk("ext", {isp_error_pin, isp_status_pin}, {isp_error_n, 1'h1});
        flash_prog_start = 1;
        cyc(1);
        flash_prog_start = 0;
        chk("busy", flash_read_mode, 1'h0);
        reset_pin_n = 0;
        cyc(2);
        chk("abort", isp_abort, 1'h1);
        cyc(2);
        reset_pin_n = 1;
        for (int n = 0; n < 700 && flash_read_mode !== 1'h1; n++) cyc(1);
        chk("rdmode", flash_read_mode, 1'h1);
        wait_ready();
        chk("drop", isp_active, 1'h0);
        rd(OFS_DEBUG_PIN_EN, 8'h00);
        rd(OFS_PMMR_TWO, 8'h7D);
        wr(OFS_PMMR_TWO, 8'h00);
        power_down = 1;
        cyc(4);
        chk("pd", pld_gated, {8'h00, pld_raw[4:0]});
        power_down = 0;
        cyc(4);
        chk("pass", pld_gated, pld_raw);
        wr(OFS_DEBUG_PIN_EN, 8'h01);
        wr(OFS_DEBUG_PIN_EN, 8'h00);
        chk("clr", isp_pins_on, 1'h0);
        test_pin_select_term = 1;
        #1;
        chk("term", isp_pins_on, 1'h1);
        {gpio_oe, gpio_out} = 16'($urandom);
        test_pin_select_term = 0;
        cyc(3);
        chk("gpio", pe_oe[3:0], gpio_oe[3:0]);
        chk("gout", pe_out[3:0], gpio_out[3:0]);
        wr(OFS_PMMR_TWO, 8'h7D);
        por(2'h2);
        rd(OFS_PMMR_TWO, 8'h00);
        reset_pin_n = 0;
        cyc(4);
        chk("ded", isp_pins_on, 1'h1);
        chk("noab", isp_abort, 1'h0);
        d = mc_q;
        {mc_re, mc_pr, mc_d} = 24'($urandom);
        cyc(1);
        chk("mcw", mc_q, (d | mc_pr) & ~mc_re);
        reset_pin_n = 1;
        wait_ready();
        por(2'h1);
        chk("blank", isp_pins_on, 1'h1);
        print_verdict();
    end
endmodule : test_reset_and_isp_pin_enable
